// ### hw/tmw_top.sv
// Summary of operation
// - all logic runs on hclk; timer tick is a one-cycle count enable.
// - phase-and-frequency-correct modes load buffered compares at BOTTOM.
// - nonzero channel A output mode hands the pin to the waveform.
// - nonzero channel B output mode hands the pin to the waveform.
// - pin driver is enabled only when its direction bit selects output.
// - non-PWM codes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - fast PWM 10 clears on match, sets at BOTTOM; 11 the reverse.
// - PWM code 01 disconnects unless top mode bit set; then toggles A only.
// - fast PWM with compare equal TOP ignores match, still acts at BOTTOM.
// - dual-slope code 10 clears on up-count match, sets on down-count match.
// - dual-slope code 11 sets on up-count match, clears on down-count match.
// - mode is control B bits 4:3 above control A bits 1:0.
// - dual-slope BOTTOM events act on the tick leaving BOTTOM; fast PWM BOTTOM events act on the tick leaving TOP.
// - modes 0, 4, 12 count or clear on match, update immediately, flag at MAX.
// - phase-correct modes update compares at TOP and flag overflow at BOTTOM.
// - modes 8 and 9 update compares and flag overflow at BOTTOM.
// - fast PWM modes update compares at BOTTOM and flag overflow at TOP.
// - dual-slope counter holds TOP for one tick before reversing.
// - dual-slope code 10 compare at BOTTOM stays low, at TOP stays high; code 11 the reverse.
`include "tmw_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tmw_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // timer tick from the prescaler, same clock
  input wire logic timer_count_enable,
  // compare output pins
  output tmw_pkg::tmw_pin_t chan_a_wave_out,
  output tmw_pkg::tmw_pin_t chan_b_wave_out
);
  import tmw_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic tmw_class_t mode_class(input logic [3:0] m);
    tmw_class_t c;
    c = tmw_norm;
    if (m == `TMW_WGM_RSV) c = tmw_rsv;
    else if (!m[3] && ~|m[1:0]) c = m[2] ? tmw_ctc : tmw_norm;
    else if (!m[3]) c = m[2] ? tmw_fast : tmw_pc;
    else if (!m[2]) c = m[1] ? tmw_pc : tmw_pfc;
    else c = m[1] ? tmw_fast : tmw_ctc;
    return c;
  endfunction : mode_class

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp_a,
                                         input logic [15:0] capt);
    logic [15:0] t;
    t = `TMW_TOP_MAX;
    if (m[3]) t = m[0] ? cmp_a : capt;
    else if (~|m[1:0]) t = m[2] ? cmp_a : `TMW_TOP_MAX;
    else if (m[1:0] == `TMW_RES_8) t = `TMW_TOP_8;
    else if (m[1:0] == `TMW_RES_9) t = `TMW_TOP_9;
    else t = `TMW_TOP_10;
    return t;
  endfunction : top_of

  function automatic logic is_pwm(input tmw_class_t c);
    return c == tmw_pc || c == tmw_pfc || c == tmw_fast;
  endfunction : is_pwm

  // pin ownership per channel
  function automatic logic connected(input logic [1:0] com, input tmw_class_t c,
                                     input logic top_bit, input logic chan_a);
    logic r;
    r = com != `TMW_COM_OFF;
    if (is_pwm(c) && com == `TMW_COM_TOGGLE && !(top_bit && chan_a)) r = 1'b0;
    return r;
  endfunction : connected

  // next waveform level for one channel on a tick
  function automatic logic wave_next(input logic cur, input logic [1:0] com, input tmw_class_t c,
                                     input logic match, input logic bottom, input logic up,
                                     input logic ign, input logic tog_ok);
    logic v;
    v = cur;
    if (com == `TMW_COM_TOGGLE) begin
      if (match && (tog_ok || !is_pwm(c))) v = ~cur;
    end else if (com != `TMW_COM_OFF) begin
      if (c == tmw_fast) begin
        if (bottom) v = ~com[0];
        else if (match && !ign) v = com[0];
      end else if (c == tmw_pc || c == tmw_pfc) begin
        if (match) v = up ? com[0] : ~com[0];
      end else if (match) begin
        v = com[0];
      end
    end
    return v;
  endfunction : wave_next

  // ****************************************
  // bus slave and configuration registers
  // ****************************************
  tmw_bus_req_t req_q, req_d;
  logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d;
  logic [15:0] buf_a_q, buf_a_d, buf_b_q, buf_b_d, capt_q, capt_d;
  logic [3:0] port_q, port_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hresp_q;
  logic [15:0] cnt_q, cnt_d, ocr_a_q, ocr_a_d, ocr_b_q, ocr_b_d;
  logic [2:0] flags_q, flags_d;
  logic up_q, up_d, oc_a_q, oc_a_d, oc_b_q, oc_b_d, blk_q, blk_d;
  tmw_pin_t pin_a_q, pin_a_d, pin_b_q, pin_b_d;
  logic wr;
  logic [3:0] mode;
  logic [1:0] com_a, com_b;
  tmw_class_t cls;
  logic [15:0] top;

  assign wr = req_q.valid && req_q.write;
  assign mode = {ctrl_b_q[`TMW_F_WGM_HI], ctrl_a_q[`TMW_F_WGM_LO]};
  assign com_a = ctrl_a_q[`TMW_F_COM_A];
  assign com_b = ctrl_a_q[`TMW_F_COM_B];
  assign cls = mode_class(mode);
  assign top = top_of(mode, ocr_a_q, capt_q);

  always_comb begin
    req_d = '0;
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    buf_a_d = buf_a_q;
    buf_b_d = buf_b_q;
    capt_d = capt_q;
    port_d = port_q;
    hrdata_d = '0;
    if (hsel && hready && htrans[1]) begin
      req_d = '{valid: 1'b1, write: hwrite, idx: haddr[`TMW_ADDR_IDX]};
    end
    if (req_d.valid && !req_d.write) begin
      unique case (req_d.idx)
        `TMW_IDX_CTRL_A: hrdata_d[7:0] = ctrl_a_q;
        `TMW_IDX_CTRL_B: hrdata_d[7:0] = ctrl_b_q;
        `TMW_IDX_COUNT: hrdata_d[`TMW_CNT_W] = cnt_q;
        `TMW_IDX_CMP_A: hrdata_d[`TMW_CNT_W] = buf_a_q;
        `TMW_IDX_CMP_B: hrdata_d[`TMW_CNT_W] = buf_b_q;
        `TMW_IDX_CAPT: hrdata_d[`TMW_CNT_W] = capt_q;
        `TMW_IDX_FLAGS: hrdata_d[`TMW_FLAGS_W] = flags_q;
        `TMW_IDX_PORT: hrdata_d[`TMW_PORT_W] = port_q;
        default: hrdata_d = '0;
      endcase
    end
    if (wr) begin
      unique case (req_q.idx)
        `TMW_IDX_CTRL_A: ctrl_a_d = hwdata[7:0] & `TMW_MASK_CTRL_A;
        `TMW_IDX_CTRL_B: ctrl_b_d = hwdata[7:0] & `TMW_MASK_CTRL_B;
        `TMW_IDX_CMP_A: buf_a_d = hwdata[`TMW_CNT_W];
        `TMW_IDX_CMP_B: buf_b_d = hwdata[`TMW_CNT_W];
        `TMW_IDX_CAPT: capt_d = hwdata[`TMW_CNT_W];
        `TMW_IDX_PORT: port_d = hwdata[`TMW_PORT_W];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      ctrl_a_q <= `TMW_CTRL_RST;
      ctrl_b_q <= `TMW_CTRL_RST;
      buf_a_q <= `TMW_BOTTOM;
      buf_b_q <= `TMW_BOTTOM;
      capt_q <= `TMW_BOTTOM;
      port_q <= `TMW_PORT_RST;
      hrdata_q <= '0;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      req_q <= req_d;
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      buf_a_q <= buf_a_d;
      buf_b_q <= buf_b_d;
      capt_q <= capt_d;
      port_q <= port_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  // ****************************************
  // counter, compare units and waveform
  // ****************************************
  logic tick, at_top, at_bot, dual, m_a, m_b, up_eff, bottom, upd;

  // the tick is an enable on hclk, never a clock of its own
  assign tick = timer_count_enable && (ctrl_b_q[`TMW_F_CS] != 3'h0);
  assign at_top = cnt_q == top;
  assign at_bot = cnt_q == `TMW_BOTTOM;
  assign dual = cls == tmw_pc || cls == tmw_pfc;
  // a counter write blocks the compare on the next tick
  assign m_a = tick && !blk_q && cnt_q == ocr_a_q;
  assign m_b = tick && !blk_q && cnt_q == ocr_b_q;
  // direction after this tick, so TOP counts as down and BOTTOM as up
  assign up_eff = up_q ? !at_top : at_bot;
  assign bottom = cls == tmw_fast && at_top;
  assign upd = (cls == tmw_fast && at_top) || (cls == tmw_pc && up_q && at_top)
    || (cls == tmw_pfc && !up_q && at_bot);

  always_comb begin
    cnt_d = cnt_q;
    up_d = up_q;
    ocr_a_d = ocr_a_q;
    ocr_b_d = ocr_b_q;
    oc_a_d = oc_a_q;
    oc_b_d = oc_b_q;
    blk_d = blk_q;
    flags_d = flags_q;
    if (wr && req_q.idx == `TMW_IDX_FLAGS) flags_d = flags_q & ~hwdata[`TMW_FLAGS_W];
    if (!is_pwm(cls)) begin
      ocr_a_d = buf_a_q;
      ocr_b_d = buf_b_q;
    end
    if (tick) begin
      blk_d = 1'b0;
      if (dual) begin
        if (up_q && !at_top) cnt_d = 16'(cnt_q + `TMW_STEP);
        else if (up_q) begin
          up_d = 1'b0;
          cnt_d = 16'(cnt_q - `TMW_STEP);
        end else if (!at_bot) cnt_d = 16'(cnt_q - `TMW_STEP);
        else begin
          up_d = 1'b1;
          cnt_d = 16'(cnt_q + `TMW_STEP);
        end
        if (!up_q && at_bot) flags_d[`TMW_FLAG_OVF] = 1'b1;
      end else if (cls == tmw_ctc || cls == tmw_fast) begin
        up_d = 1'b1;
        cnt_d = at_top ? `TMW_BOTTOM : 16'(cnt_q + `TMW_STEP);
        if (cls == tmw_fast ? at_top : cnt_q == `TMW_TOP_MAX) flags_d[`TMW_FLAG_OVF] = 1'b1;
      end else begin
        up_d = 1'b1;
        cnt_d = 16'(cnt_q + `TMW_STEP);
        if (cnt_q == `TMW_TOP_MAX) flags_d[`TMW_FLAG_OVF] = 1'b1;
      end
      if (upd) begin
        ocr_a_d = buf_a_q;
        ocr_b_d = buf_b_q;
      end
      if (m_a) flags_d[`TMW_FLAG_MA] = 1'b1;
      if (m_b) flags_d[`TMW_FLAG_MB] = 1'b1;
      oc_a_d = wave_next(oc_a_q, com_a, cls, m_a, bottom, up_eff, ocr_a_q == top,
                         mode[`TMW_WGM_TOP_BIT]);
      oc_b_d = wave_next(oc_b_q, com_b, cls, m_b, bottom, up_eff, ocr_b_q == top, 1'b0);
    end
    if (wr && req_q.idx == `TMW_IDX_COUNT) begin
      cnt_d = hwdata[`TMW_CNT_W];
      blk_d = 1'b1;
    end
    pin_a_d.oe = port_q[`TMW_PORT_DIR_A];
    pin_b_d.oe = port_q[`TMW_PORT_DIR_B];
    pin_a_d.out = connected(com_a, cls, mode[`TMW_WGM_TOP_BIT], 1'b1) ? oc_a_q
      : port_q[`TMW_PORT_VAL_A];
    pin_b_d.out = connected(com_b, cls, mode[`TMW_WGM_TOP_BIT], 1'b0) ? oc_b_q
      : port_q[`TMW_PORT_VAL_B];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= `TMW_BOTTOM;
      up_q <= 1'b1;
      ocr_a_q <= `TMW_BOTTOM;
      ocr_b_q <= `TMW_BOTTOM;
      oc_a_q <= 1'b0;
      oc_b_q <= 1'b0;
      blk_q <= 1'b0;
      flags_q <= `TMW_FLAGS_RST;
      pin_a_q <= '0;
      pin_b_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      up_q <= up_d;
      ocr_a_q <= ocr_a_d;
      ocr_b_q <= ocr_b_d;
      oc_a_q <= oc_a_d;
      oc_b_q <= oc_b_d;
      blk_q <= blk_d;
      flags_q <= flags_d;
      pin_a_q <= pin_a_d;
      pin_b_q <= pin_b_d;
    end
  end

  assign chan_a_wave_out = pin_a_q;
  assign chan_b_wave_out = pin_b_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_top_turn;
    dual && tick && up_q && at_top;
  endsequence
  sequence s_pfc_bottom;
    cls == tmw_pfc && tick && !up_q && at_bot;
  endsequence

  match_flag_a: assert property (
    m_a |=> flags_q[`TMW_FLAG_MA]) else $error("match flag a not set");
  pfc_bottom_load_a: assert property (
    s_pfc_bottom |=> ocr_a_q == $past(buf_a_q) && flags_q[`TMW_FLAG_OVF])
    else $error("compare not loaded at bottom");
  pin_take_a: assert property (
    com_a == `TMW_COM_SET && port_q[`TMW_PORT_DIR_A] |=> chan_a_wave_out == {$past(oc_a_q), 1'b1})
    else $error("channel a did not take pin");
  pin_dir_gate_a: assert property (
    !port_q[`TMW_PORT_DIR_B] |=> !chan_b_wave_out.oe) else $error("pin driven without direction");
  match_set_a: assert property (
    !is_pwm(cls) && com_a == `TMW_COM_SET && m_a |=> oc_a_q) else $error("set on match failed");
  fast_bottom_set_a: assert property (
    cls == tmw_fast && com_a == `TMW_COM_CLR && tick && at_top && ocr_a_q != top |=> oc_a_q)
    else $error("fast pwm bottom set failed");
  fast_top_ignore_a: assert property (
    cls == tmw_fast && com_a == `TMW_COM_SET && tick && at_top |=> !oc_a_q)
    else $error("fast pwm top match not ignored");
  reserved_b_off_a: assert property (
    is_pwm(cls) && com_b == `TMW_COM_TOGGLE |=> chan_b_wave_out.out == $past(port_q[`TMW_PORT_VAL_B]))
    else $error("channel b code 01 not disconnected");
  dual_up_clear_a: assert property (
    dual && com_a == `TMW_COM_CLR && m_a && up_eff |=> !oc_a_q) else $error("up-count clear failed");
  dual_down_clear_a: assert property (
    dual && com_a == `TMW_COM_SET && m_a && !up_eff |=> !oc_a_q) else $error("down-count clear failed");
  top_hold_a: assert property (
    s_top_turn |=> !up_q && cnt_q == 16'($past(top) - `TMW_STEP)) else $error("top not turned after one tick");
endmodule : tmw_top
`default_nettype wire

// ### hw/tmw_defs.svh
`ifndef TMW_DEFS_SVH
`define TMW_DEFS_SVH
// register indices; byte address is four times the index
`define TMW_IDX_CTRL_A 6'h2F
`define TMW_IDX_CTRL_B 6'h2E
`define TMW_IDX_COUNT 6'h30
`define TMW_IDX_CMP_A 6'h31
`define TMW_IDX_CMP_B 6'h32
`define TMW_IDX_CAPT 6'h33
`define TMW_IDX_FLAGS 6'h34
`define TMW_IDX_PORT 6'h35
`define TMW_ADDR_IDX 7:2
// reset values and writable masks
`define TMW_CTRL_RST 8'h00
`define TMW_MASK_CTRL_A 8'hF3
`define TMW_MASK_CTRL_B 8'hDF
`define TMW_PORT_RST 4'h0
`define TMW_FLAGS_RST 3'h0
// control fields
`define TMW_F_COM_A 7:6
`define TMW_F_COM_B 5:4
`define TMW_F_WGM_LO 1:0
`define TMW_F_WGM_HI 4:3
`define TMW_F_CS 2:0
`define TMW_WGM_TOP_BIT 3
`define TMW_WGM_RSV 4'hD
// flag and port bits
`define TMW_FLAG_OVF 0
`define TMW_FLAG_MA 1
`define TMW_FLAG_MB 2
`define TMW_FLAGS_W 2:0
`define TMW_PORT_DIR_A 0
`define TMW_PORT_DIR_B 1
`define TMW_PORT_VAL_A 2
`define TMW_PORT_VAL_B 3
`define TMW_PORT_W 3:0
// output-mode codes
`define TMW_COM_OFF 2'h0
`define TMW_COM_TOGGLE 2'h1
`define TMW_COM_CLR 2'h2
`define TMW_COM_SET 2'h3
// fixed resolutions selected by the low mode bits
`define TMW_RES_8 2'h1
`define TMW_RES_9 2'h2
// counter values
`define TMW_TOP_MAX 16'hFFFF
`define TMW_TOP_8 16'h00FF
`define TMW_TOP_9 16'h01FF
`define TMW_TOP_10 16'h03FF
`define TMW_BOTTOM 16'h0000
`define TMW_STEP 16'h0001
`define TMW_CNT_W 15:0
`endif

// ### hw/tmw_pkg.sv
`default_nettype none
package tmw_pkg;
  typedef enum logic [2:0] {
    tmw_norm, tmw_ctc, tmw_pc, tmw_pfc, tmw_fast, tmw_rsv
  } tmw_class_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] idx;
  } tmw_bus_req_t;
  typedef struct packed {
    logic out;
    logic oe;
  } tmw_pin_t;
endpackage : tmw_pkg
`default_nettype wire

// ### test/tmw_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmw_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tmw_top_bench;
  import tmw_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, timer_count_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [1:0] w;
  tmw_pin_t chan_a_wave_out, chan_b_wave_out;
  int errors = 0;
  int total_checks = 0;
  int cnt, dir, ovf, ma, mb, tk, md, ca, cb, cpa, cpb, cap, prt;
  // mode, code a, code b, compare a, compare b, capture, start count, cycles
  int sc [13][8] = '{
    '{0, 1, 2, 'hFFF4, 'hFFF8, 0, 'hFFF0, 80}, '{4, 3, 1, 6, 3, 0, 0, 200},
    '{12, 2, 3, 4, 9, 9, 0, 200}, '{14, 2, 3, 3, 9, 9, 0, 200},
    '{15, 1, 1, 7, 2, 0, 0, 200}, '{5, 3, 2, 'h80, 'h10, 0, 0, 1200},
    '{10, 2, 3, 3, 8, 8, 0, 300}, '{11, 1, 2, 6, 2, 0, 0, 300},
    '{8, 3, 2, 5, 1, 7, 0, 300}, '{9, 2, 3, 5, 0, 0, 0, 300},
    '{1, 2, 0, 'h40, 'h20, 0, 0, 2200}, '{2, 3, 2, 'h100, 'h20, 0, 0, 4200},
    '{7, 2, 3, 'h200, 'h3FF, 0, 0, 4400}};

  tmw_top i_tmw_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_count_enable(timer_count_enable),
    .chan_a_wave_out(chan_a_wave_out), .chan_b_wave_out(chan_b_wave_out));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ****************************************
  // reference model of counter and outputs
  // ****************************************
  function automatic int top_of();
    case (md)
      0, 13: return 'hFFFF;
      1, 5: return 'hFF;
      2, 6: return 'h1FF;
      3, 7: return 'h3FF;
      4, 9, 11, 15: return cpa;
      default: return cap;
    endcase
  endfunction : top_of

  function automatic logic pin(int ch);
    int o;
    logic pwm, conn;
    o = ch ? cb : ca;
    pwm = md inside {[1:3], [5:11], 14, 15};
    conn = (o != 0) && !(pwm && o == 1 && (ch == 1 || md < 8));
    return conn ? w[ch] : logic'((prt >> (2 + ch)) & 1);
  endfunction : pin

  task automatic step();
    int t, c[2], o[2];
    logic dual, fast;
    c[0] = cpa; c[1] = cpb; o[0] = ca; o[1] = cb;
    t = top_of();
    dual = md inside {[1:3], [8:11]};
    fast = md inside {[5:7], 14, 15};
    if (dual && cnt == t) dir = 0;
    if (dual && cnt == 0) begin
      if (dir == 0) ovf = 1;
      dir = 1;
    end
    for (int ch = 0; ch < 2; ch++) begin
      if (cnt == c[ch]) begin
        if (ch == 1) mb = 1; else ma = 1;
        if (o[ch] == 1 && (!(dual || fast) || (ch == 0 && md >= 8))) w[ch] = ~w[ch];
        else if (dual && o[ch] >= 2) w[ch] = (o[ch] == 3) ^ (dir == 0);
        else if (o[ch] >= 2 && !(fast && cnt == t)) w[ch] = (o[ch] == 3);
      end
      if (fast && cnt == t && o[ch] >= 2) w[ch] = (o[ch] == 2);
    end
    if (!dual && cnt == (fast ? t : 'hFFFF)) ovf = 1;
    cnt = dual ? cnt + (dir ? 1 : -1) : (cnt == t ? 0 : (cnt + 1) & 'hFFFF);
  endtask : step

  // ****************************************
  // bus and run tasks
  // ****************************************
  task automatic close_out();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic wrdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 64) begin
      errors++;
      close_out();
    end else begin
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
    end
  endtask : wrdy

  task automatic xfer(input logic wr, input logic [5:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, i, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= 3'h2;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
  endtask : xfer

  task automatic rst();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : rst

  task automatic run(input int n);
    int nt;
    logic ea, eb;
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      nt = (i < n - 1) ? int'($urandom % 2) : 0;
      timer_count_enable <= nt[0];
      ea = pin(0);
      eb = pin(1);
      if (tk != 0) step();
      tk = nt;
      #1;
      `CHK("pin a", ea, chan_a_wave_out.out)
      `CHK("pin b", eb, chan_b_wave_out.out)
      `CHK("oe a", logic'(prt & 1), chan_a_wave_out.oe)
      `CHK("oe b", logic'((prt >> 1) & 1), chan_b_wave_out.oe)
    end
    @(posedge hclk);
  endtask : run

  task automatic scen(input int k);
    rst();
    md = sc[k][0]; ca = sc[k][1]; cb = sc[k][2]; cpa = sc[k][3];
    cpb = sc[k][4]; cap = sc[k][5]; cnt = sc[k][6];
    prt = $urandom % 16;
    xfer(1'b1, `TMW_IDX_PORT, 32'(prt));
    xfer(1'b1, `TMW_IDX_CAPT, 32'(cap));
    xfer(1'b1, `TMW_IDX_CMP_A, 32'(cpa));
    xfer(1'b1, `TMW_IDX_CMP_B, 32'(cpb));
    if (cnt != 0) xfer(1'b1, `TMW_IDX_COUNT, 32'(cnt));
    xfer(1'b1, `TMW_IDX_CTRL_A, 32'((ca << 6) | (cb << 4) | (md & 3)));
    xfer(1'b1, `TMW_IDX_CTRL_B, 32'(((md >> 2) << 3) | 1));
    dir = 1; w = 2'h0; ovf = 0; ma = 0; mb = 0; tk = 0;
    run(sc[k][7]);
    xfer(1'b0, `TMW_IDX_FLAGS, 32'h0);
    `CHK("flags", 32'((mb << 2) | (ma << 1) | ovf), rd)
    xfer(1'b0, `TMW_IDX_COUNT, 32'h0);
    `CHK("count", 32'(cnt), rd)
    xfer(1'b1, `TMW_IDX_FLAGS, 32'h7);
    xfer(1'b0, `TMW_IDX_FLAGS, 32'h0);
    `CHK("flags clr", 32'h0, rd)
  endtask : scen

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    timer_count_enable = 1'b0;
    void'($urandom(5066));
    rst();
    xfer(1'b0, `TMW_IDX_CTRL_A, 32'h0);
    `CHK("ctrl a rst", 32'h0, rd)
    xfer(1'b0, `TMW_IDX_CTRL_B, 32'h0);
    `CHK("ctrl b rst", 32'h0, rd)
    xfer(1'b1, `TMW_IDX_CTRL_A, 32'hFFFFFFFF);
    xfer(1'b0, `TMW_IDX_CTRL_A, 32'h0);
    `CHK("ctrl a rw", 32'h000000F3, rd)
    xfer(1'b1, `TMW_IDX_CTRL_B, 32'hFFFFFFFF);
    xfer(1'b0, `TMW_IDX_CTRL_B, 32'h0);
    `CHK("ctrl b rw", 32'h000000DF, rd)
    xfer(1'b0, 6'h3F, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int k = 0; k < 13; k++) scen(k);
    close_out();
  end
endmodule : tmw_top_bench
`default_nettype wire
